// File: core/trca_pkg.sv
package trca_pkg;

  // Accumulator geometry: one stage per tape track, parity included.
  localparam int unsigned ACC_W = 9;
  localparam logic [ACC_W-1:0] ACC_RST = 9'h000;

  // Stages four to seven (bits 3..6) take the complement of their
  // predecessor when the last stage feeds back.
  localparam logic [ACC_W-1:0] FB_MASK = 9'h078;

  // Pattern left in the accumulator by an error-free record.
  localparam logic [ACC_W-1:0] RESIDUE = 9'h1d7;

  // Character-time counter.
  localparam int unsigned PER_W = 16;
  localparam logic [PER_W-1:0] PER_RST = 16'h0000;
  localparam logic [PER_W-1:0] PER_ONE = 16'h0001;

  // Blank character times before the check and before the parity character.
  localparam int unsigned BLK_W = 2;
  localparam logic [BLK_W-1:0] BLK_RST = 2'h0;
  localparam logic [BLK_W-1:0] BLK_ONE = 2'h1;
  localparam logic [BLK_W-1:0] BLANK_TIMES = 2'h3;
  localparam logic [BLK_W-1:0] BLANK_LAST = BLANK_TIMES - BLK_ONE;

  // Number of strobe lines and the index of each line.
  localparam int unsigned NUM_STROBES = 2;
  localparam int unsigned STB_FIRST = 0;
  localparam int unsigned STB_SECOND = 1;

  // Record position of the accumulator.
  typedef enum logic [2:0] {
    TRCA_DATA,
    TRCA_GAP_CHECK,
    TRCA_CHECK,
    TRCA_GAP_PARITY,
    TRCA_PARITY,
    TRCA_DONE
  } trca_state_e;

endpackage

// File: core/trca_sync.sv
`timescale 1ns/1ps

module trca_sync (
  input  wire logic I_CLK,
  input  wire logic I_RST,
  input  wire logic i_async,
  output logic      o_level
);
  import trca_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } trca_sync_s;

  trca_sync_s r;
  trca_sync_s r_nxt;

  // The first stage feeds only the second; the filtered level changes once
  // the second and third stages agree, which rejects a single-cycle glitch.
  always_comb begin
    r_nxt       = r;
    r_nxt.s1    = i_async;
    r_nxt.s2    = r.s1;
    r_nxt.s3    = r.s2;
    r_nxt.level = (r.s2 == r.s3) ? r.s2 : r.level;
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign o_level = r.level;

endmodule

// File: core/trca_top.sv
`timescale 1ns/1ps

// Overview of operation
// - Last stage set: stages four-seven take complemented predecessor, first stage sets.
// - Last stage clear: shift step moves every stage one place, no complementing.
// - Common reset asynchronously clears all stages and the phase flag.
// - Stage inputs come from bus lines in forward, reverse lines in reverse.
// - Reverse request from channel; forward is its inverse; selects are complementary.
// - Phase flag toggles on every phase pulse, alternating shift and XOR steps.
// - With phase flag set, each stage XORs its input bit, no shifting.
// - Each character strobe while transfer enabled, in a data or check position, makes a phase pulse, applied at its end.
// - First character: shift leaves zero, XOR leaves the first character.
// - Shift-then-XOR repeats per data character, giving the running code.
// - After last data character, three blank times, check character in the fourth.
// - After check character, three blank times, then the parity character.
// - After the last data character the period counter keeps counting.
// - Error-free record leaves the fixed residue pattern after the check character.
// - Reverse reading takes inputs from the nine reverse read lines.
// - The accumulator is nine stages wide, one per track.
module trca_top (
  input  wire logic                          I_CLK,
  input  wire logic                          I_RST,
  input  wire logic                          I_REVERSE_DIR_REQUEST,
  input  wire logic                          I_READ_TRANSFER_ENABLE,
  input  wire logic                          I_CHAR_STROBE_FIRST,
  input  wire logic                          I_CHAR_STROBE_SECOND,
  input  wire logic [trca_pkg::ACC_W-1:0]    I_BUS_DATA_BIT,
  input  wire logic [trca_pkg::ACC_W-1:0]    I_REVERSE_READ_BIT,
  input  wire logic [trca_pkg::PER_W-1:0]    I_CHAR_PERIOD,
  output logic      [trca_pkg::ACC_W-1:0]    O_ACCUM,
  output logic                               O_SHIFT_PHASE_ACTIVE,
  output logic                               O_FORWARD_DIR,
  output logic                               O_FORWARD_SELECT,
  output logic                               O_REVERSE_SELECT,
  output logic                               O_CHECK_SLOT,
  output logic                               O_RESIDUE_VALID,
  output logic                               O_RESIDUE_MATCH,
  output logic      [trca_pkg::ACC_W-1:0]    O_PARITY_CHAR,
  output logic                               O_PARITY_VALID,
  output trca_pkg::trca_state_e              O_RECORD_STATE
);
  import trca_pkg::*;

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic             phase;
    logic             fwd_dir;
    logic             forward_select;
    logic             reverse_select;
    logic             prev_first;
    logic             prev_second;
    logic             step;
    trca_state_e      state;
    logic             seen_char;
    logic [PER_W-1:0] period_cnt;
    logic [BLK_W-1:0] blanks;
    logic             residue_valid;
    logic             residue_match;
    logic [ACC_W-1:0] parity_char;
    logic             parity_valid;
  } trca_top_s;

  trca_top_s r;
  trca_top_s r_nxt;

  logic [NUM_STROBES-1:0] strobe_raw;
  logic [NUM_STROBES-1:0] strobe_lvl;
  logic [ACC_W-1:0]       gated_input_bit;
  logic [ACC_W-1:0]       shift_val;
  logic [ACC_W-1:0]       xor_val;
  logic [ACC_W-1:0]       step_val;
  logic [ACC_W-1:0]       residue_eq;
  logic [PER_W-1:0]       period_last;
  logic                   period_set;
  logic                   last_stage;
  logic                   fall_first;
  logic                   fall_second;
  logic                   fall_any;
  logic                   in_data;
  logic                   in_check;
  logic                   in_parity;
  logic                   fold_window;
  logic                   char_tick;
  logic                   step_shift;
  logic                   step_xor;
  logic                   parity_take;

  assign strobe_raw[STB_FIRST]  = I_CHAR_STROBE_FIRST;
  assign strobe_raw[STB_SECOND] = I_CHAR_STROBE_SECOND;

  // The strobes are produced by the read path timing, not by this clock.
  for (genvar s = 0; s < NUM_STROBES; s++) begin : g_strobe_sync
    trca_sync u_sync (
      .I_CLK   (I_CLK),
      .I_RST   (I_RST),
      .i_async (strobe_raw[s]),
      .o_level (strobe_lvl[s])
    );
  end

  assign last_stage  = r.acc[ACC_W-1];
  assign fall_first  = r.prev_first & ~strobe_lvl[STB_FIRST];
  assign fall_second = r.prev_second & ~strobe_lvl[STB_SECOND];

  // Either strobe advances the phase, so the phase flag alone
  // decides whether a falling edge shifts or folds.
  assign fall_any    = fall_first | fall_second;

  // Decoded record position.
  assign in_data     = (r.state == TRCA_DATA);
  assign in_check    = (r.state == TRCA_CHECK);
  assign in_parity   = (r.state == TRCA_PARITY);

  // Strobes only clock the accumulator while a data or the check character
  // can be on the bus; blank positions and the parity character leave it alone.
  assign fold_window = in_data || in_check;

  // A period of zero would wrap period_last round to all ones, so it is treated as no timing.
  // The compare is greater-or-equal so that a period shortened on the fly
  // still ends the current character time instead of letting the timer wrap.
  assign period_set  = (I_CHAR_PERIOD != PER_RST);
  assign period_last = I_CHAR_PERIOD - PER_ONE;
  assign char_tick   = period_set && (r.period_cnt >= period_last);

  // The registered step is qualified again, so a strobe that lands on the
  // edge into a blank position cannot fold a stray character.
  assign step_shift  = r.step && fold_window && !r.phase;
  assign step_xor    = r.step && fold_window && r.phase;

  // The parity character is captured, never folded into the stages.
  assign parity_take = in_parity && fall_second && I_READ_TRANSFER_ENABLE;

  for (genvar i = 0; i < ACC_W; i++) begin : g_stage
    assign gated_input_bit[i] = (r.forward_select & I_BUS_DATA_BIT[i])
                              | (r.reverse_select & I_REVERSE_READ_BIT[i]);
    if (i == 0) begin : g_first
      // The last stage wraps round, so the first stage sets when it is set.
      assign shift_val[i] = last_stage;
    end else begin : g_rest
      assign shift_val[i] = (FB_MASK[i] & last_stage) ? ~r.acc[i-1] : r.acc[i-1];
    end
    assign xor_val[i] = r.acc[i] ^ gated_input_bit[i];
    // Phase clear means this step shifts; phase set means it folds the input.
    assign step_val[i]   = r.phase ? xor_val[i] : shift_val[i];
    assign residue_eq[i] = (xor_val[i] == RESIDUE[i]);
  end

  always_comb begin
    r_nxt = r;

    // Direction controls follow the channel's reverse request.
    r_nxt.fwd_dir = ~I_REVERSE_DIR_REQUEST;
    r_nxt.reverse_select = ~r_nxt.fwd_dir;
    r_nxt.forward_select = ~r_nxt.reverse_select;

    r_nxt.prev_first  = strobe_lvl[STB_FIRST];
    r_nxt.prev_second = strobe_lvl[STB_SECOND];

    // One cycle between seeing the falling edge and clocking the stages.
    r_nxt.step = fall_any & I_READ_TRANSFER_ENABLE & fold_window;

    // Free-running character timer; data characters restart it.
    r_nxt.period_cnt = r.period_cnt + PER_ONE;
    if (char_tick) begin
      r_nxt.period_cnt = PER_RST;
    end

    // Both steps toggle the phase; only the fold restarts the character
    // timer, since that is the moment a character has really arrived.
    if (step_shift || step_xor) begin
      r_nxt.phase = ~r.phase;
      r_nxt.acc   = step_val;
    end
    if (step_xor) begin
      r_nxt.period_cnt = PER_RST;
    end

    unique case (r.state)
      TRCA_DATA: begin
        if (step_xor) begin
          r_nxt.seen_char = 1'b1;
        end else if (r.seen_char && char_tick) begin
          // No character in a whole period: the record's data has ended and
          // this was the first blank. The tick has already restarted the timer.
          r_nxt.state  = TRCA_GAP_CHECK;
          r_nxt.blanks = BLK_ONE;
        end
      end
      TRCA_GAP_CHECK: begin
        if (char_tick) begin
          if (r.blanks == BLANK_LAST) begin
            r_nxt.state = TRCA_CHECK;
          end else begin
            r_nxt.blanks = r.blanks + BLK_ONE;
          end
        end
      end
      TRCA_CHECK: begin
        if (step_xor) begin
          // The match is judged on the value being folded in now, so the
          // flag and the stages become visible on the same edge.
          r_nxt.state         = TRCA_GAP_PARITY;
          r_nxt.blanks        = BLK_RST;
          r_nxt.residue_valid = 1'b1;
          r_nxt.residue_match = &residue_eq;
        end
      end
      TRCA_GAP_PARITY: begin
        if (char_tick) begin
          if (r.blanks == BLANK_LAST) begin
            r_nxt.state = TRCA_PARITY;
          end else begin
            r_nxt.blanks = r.blanks + BLK_ONE;
          end
        end
      end
      TRCA_PARITY: begin
        if (parity_take) begin
          r_nxt.parity_char  = gated_input_bit;
          r_nxt.parity_valid = 1'b1;
          r_nxt.state        = TRCA_DONE;
        end
      end
      TRCA_DONE: begin
        r_nxt.state = TRCA_DONE;
      end
      default: begin
        r_nxt.state = TRCA_DONE;
      end
    endcase
  end

  // All-zero is the cleared record state: empty stages, phase flag clear,
  // data position. Only the common reset returns here, so one reset per
  // record is expected.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign O_ACCUM              = r.acc;
  assign O_SHIFT_PHASE_ACTIVE = ~r.phase;
  assign O_FORWARD_DIR        = r.fwd_dir;
  assign O_FORWARD_SELECT     = r.forward_select;
  assign O_REVERSE_SELECT     = r.reverse_select;
  assign O_CHECK_SLOT         = in_check;
  assign O_RESIDUE_VALID      = r.residue_valid;
  assign O_RESIDUE_MATCH      = r.residue_match;
  assign O_PARITY_CHAR        = r.parity_char;
  assign O_PARITY_VALID       = r.parity_valid;
  assign O_RECORD_STATE       = r.state;

endmodule

// File: test/trca_monitor.sv
`timescale 1ns/1ps
module trca_monitor (
  input wire logic                        I_CLK,
  input wire logic                        I_RST,
  input wire logic                        I_REVERSE_DIR_REQUEST,
  input wire logic                        I_READ_TRANSFER_ENABLE,
  input wire logic                        I_CHAR_STROBE_FIRST,
  input wire logic [trca_pkg::ACC_W-1:0]  I_BUS_DATA_BIT,
  input wire logic [trca_pkg::ACC_W-1:0]  I_REVERSE_READ_BIT,
  input wire logic [trca_pkg::ACC_W-1:0]  O_ACCUM,
  input wire logic                        O_SHIFT_PHASE_ACTIVE,
  input wire logic                        O_FORWARD_DIR,
  input wire logic                        O_FORWARD_SELECT,
  input wire logic                        O_REVERSE_SELECT,
  input wire logic                        O_RESIDUE_VALID,
  input wire logic                        O_RESIDUE_MATCH,
  input wire logic                        O_PARITY_VALID,
  input wire trca_pkg::trca_state_e       O_RECORD_STATE
);
  import trca_pkg::*;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  function automatic logic [ACC_W-1:0] shf(input logic [ACC_W-1:0] a);
    return {a[ACC_W-2:0], a[ACC_W-1]} ^ (a[ACC_W-1] ? FB_MASK : ACC_RST);
  endfunction
  dir_lag_a: assert property (
    !$past(I_RST) |-> O_FORWARD_DIR == !$past(I_REVERSE_DIR_REQUEST)) else $error("bad direction");
  sel_pair_a: assert property (!$past(I_RST) |->
    O_FORWARD_SELECT == O_FORWARD_DIR && O_REVERSE_SELECT == !O_FORWARD_DIR) else $error("bad selects");
  shift_step_a: assert property (
    $fell(O_SHIFT_PHASE_ACTIVE) |-> O_ACCUM == shf($past(O_ACCUM))) else $error("bad shift step");
  xor_step_a: assert property ($rose(O_SHIFT_PHASE_ACTIVE) |-> O_ACCUM == ($past(O_ACCUM) ^
    ($past(O_FORWARD_SELECT) ? $past(I_BUS_DATA_BIT) : $past(I_REVERSE_READ_BIT))))
    else $error("bad xor step");
  accum_hold_a: assert property (
    $stable(O_SHIFT_PHASE_ACTIVE) && !$past(I_RST) |-> $stable(O_ACCUM)) else $error("stray update");
  step_latency_a: assert property ($fell(I_CHAR_STROBE_FIRST) && I_READ_TRANSFER_ENABLE &&
    O_SHIFT_PHASE_ACTIVE && O_RECORD_STATE == TRCA_DATA |-> ##[4:7] !O_SHIFT_PHASE_ACTIVE)
    else $error("step late");
  refuse_off_a: assert property (
    !I_READ_TRANSFER_ENABLE [*8] |-> $stable(O_SHIFT_PHASE_ACTIVE)) else $error("step while off");
  residue_flag_a: assert property ($rose(O_RESIDUE_VALID) |->
    O_RESIDUE_MATCH == (O_ACCUM == RESIDUE) && $past(O_RECORD_STATE) == TRCA_CHECK)
    else $error("bad residue flag");
  state_order_a: assert property (O_RECORD_STATE != $past(O_RECORD_STATE) && !$past(I_RST) |->
    3'(O_RECORD_STATE) == 3'($past(O_RECORD_STATE)) + 3'h1) else $error("bad state order");
  parity_done_a: assert property (
    $rose(O_PARITY_VALID) |-> O_RECORD_STATE == TRCA_DONE) else $error("bad parity capture");
  cover property ($fell(O_SHIFT_PHASE_ACTIVE) && $past(O_ACCUM[ACC_W-1]));
  cover property ($rose(O_RESIDUE_MATCH));
  cover property ($rose(O_PARITY_VALID));
endmodule

bind trca_top trca_monitor trca_monitor_i (.I_CLK(I_CLK), .I_RST(I_RST),
  .I_REVERSE_DIR_REQUEST(I_REVERSE_DIR_REQUEST), .I_READ_TRANSFER_ENABLE(I_READ_TRANSFER_ENABLE),
  .I_CHAR_STROBE_FIRST(I_CHAR_STROBE_FIRST), .I_BUS_DATA_BIT(I_BUS_DATA_BIT),
  .I_REVERSE_READ_BIT(I_REVERSE_READ_BIT), .O_ACCUM(O_ACCUM),
  .O_SHIFT_PHASE_ACTIVE(O_SHIFT_PHASE_ACTIVE), .O_FORWARD_DIR(O_FORWARD_DIR),
  .O_FORWARD_SELECT(O_FORWARD_SELECT), .O_REVERSE_SELECT(O_REVERSE_SELECT),
  .O_RESIDUE_VALID(O_RESIDUE_VALID), .O_RESIDUE_MATCH(O_RESIDUE_MATCH),
  .O_PARITY_VALID(O_PARITY_VALID), .O_RECORD_STATE(O_RECORD_STATE));

// File: test/trca_reader.sv
`timescale 1ns/1ps
module trca_reader (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  input  wire logic                        i_go,
  input  wire logic                        i_rev,
  input  wire logic [trca_pkg::ACC_W-1:0]  i_char,
  output logic                             o_busy,
  output logic                             o_stb_first,
  output logic                             o_stb_second,
  output logic      [trca_pkg::ACC_W-1:0]  o_bus,
  output logic      [trca_pkg::ACC_W-1:0]  o_rev_bits
);
  import trca_pkg::*;
  logic [4:0] cnt_r;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= 5'h00;
    end else if (cnt_r == 5'h19) begin
      cnt_r <= 5'h00;
    end else if (cnt_r != 5'h00 || i_go) begin
      cnt_r <= cnt_r + 5'h01;
    end
  end
  // Four cycles high and long gaps, so the synchroniser sees every edge.
  assign o_stb_first  = cnt_r >= 5'h02 && cnt_r <= 5'h05;
  assign o_stb_second = cnt_r >= 5'h0c && cnt_r <= 5'h0f;
  assign o_busy       = cnt_r != 5'h00;
  // Unselected or idle lines show the inverse so a wrong select cannot pass by luck.
  assign o_bus        = (o_busy && !i_rev) ? i_char : ~i_char;
  assign o_rev_bits   = (o_busy && i_rev) ? i_char : ~i_char;
endmodule

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
  import trca_pkg::*;
  logic              I_CLK = 1'b0, I_RST = 1'b1, reverse_dir_request = 1'b0, en = 1'b0, go = 1'b0;
  logic [ACC_W-1:0]  chr = ACC_RST, exp_acc = ACC_RST, acc, bus, rbits, pchar;
  logic              sf, ss, busy, phase, fdir, fsel, rsel, cslot, rvalid, rmatch, pvalid;
  trca_state_e       state;
  int                err_count = 0, check_count = 0, cyc = 0, n;
  logic [10:0]       rows [6] = '{11'h2a5, 11'h3ff, 11'h73c, 11'h0f0, 11'h701, 11'h3e7};
  logic [ACC_W-1:0]  want [6] = '{9'h0a5, 9'h0b5, 9'h056, 9'h056, 9'h1ad, 9'h0c4};
  trca_reader trca_reader_i (.i_clk(I_CLK), .i_rst(I_RST), .i_go(go), .i_rev(reverse_dir_request), .i_char(chr),
    .o_busy(busy), .o_stb_first(sf), .o_stb_second(ss), .o_bus(bus), .o_rev_bits(rbits));
  trca_top trca_top_i (.I_CLK(I_CLK), .I_RST(I_RST), .I_REVERSE_DIR_REQUEST(reverse_dir_request),
    .I_READ_TRANSFER_ENABLE(en), .I_CHAR_STROBE_FIRST(sf), .I_CHAR_STROBE_SECOND(ss),
    .I_BUS_DATA_BIT(bus), .I_REVERSE_READ_BIT(rbits), .I_CHAR_PERIOD(16'h0050), .O_ACCUM(acc),
    .O_SHIFT_PHASE_ACTIVE(phase), .O_FORWARD_DIR(fdir), .O_FORWARD_SELECT(fsel),
    .O_REVERSE_SELECT(rsel), .O_CHECK_SLOT(cslot), .O_RESIDUE_VALID(rvalid),
    .O_RESIDUE_MATCH(rmatch), .O_PARITY_CHAR(pchar), .O_PARITY_VALID(pvalid),
    .O_RECORD_STATE(state));
  always #25 I_CLK = ~I_CLK;
  function automatic logic [ACC_W-1:0] shf(input logic [ACC_W-1:0] a);
    return {a[ACC_W-2:0], a[ACC_W-1]} ^ (a[ACC_W-1] ? FB_MASK : ACC_RST);
  endfunction
  task automatic complete_run();
    if (err_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [ACC_W-1:0] got, input logic [ACC_W-1:0] want);
    check_count++;
    if (got !== want) begin
      err_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, want);
    end
  endtask
  // One character: shift strobe then xor strobe; s says whether a step should land.
  task automatic pair(input logic [ACC_W-1:0] c, input logic r, input logic e, input logic s);
    chr <= c;
    reverse_dir_request <= r;
    en  <= e;
    go  <= 1'b1;
    @(posedge I_CLK);
    go <= 1'b0;
    repeat (2) @(posedge I_CLK);
    for (n = 0; n < 40 && busy; n++) @(posedge I_CLK);
    if (s) exp_acc = shf(exp_acc) ^ c;
    chk(acc, exp_acc);
    chk({5'h00, phase, fdir, fsel, rsel}, {5'h00, 1'b1, !r, !r, r});
  endtask
  task automatic wait_check();
    for (n = 0; n < 400 && cslot !== 1'b1; n++) @(posedge I_CLK);
  endtask
  always @(posedge I_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    repeat (10) @(posedge I_CLK);
    chk(acc, ACC_RST);
    chk({8'h00, phase}, 9'h001);
    I_RST <= 1'b0;
    repeat (4) @(posedge I_CLK);
    foreach (rows[i]) begin
      pair(rows[i][8:0], rows[i][10], rows[i][9], rows[i][9]);
      chk(acc, want[i]);
    end
    wait_check();
    chk({8'h00, 1'(n > 225 && n < 250)}, 9'h001);
    pair(shf(exp_acc) ^ RESIDUE, 1'b0, 1'b1, 1'b1);
    chk({7'h00, rvalid, rmatch}, 9'h003);
    for (n = 0; n < 400 && state !== TRCA_PARITY; n++) @(posedge I_CLK);
    chk({8'h00, 1'(n > 225 && n < 250)}, 9'h001);
    pair(9'h12d, 1'b0, 1'b1, 1'b0);
    chk(pchar, 9'h12d);
    chk({7'h00, pvalid, 1'(state == TRCA_DONE)}, 9'h003);
    I_RST <= 1'b1;
    @(posedge I_CLK);
    chk({6'h00, rvalid, pvalid, 1'(acc != ACC_RST)}, 9'h000);
    I_RST <= 1'b0;
    exp_acc = ACC_RST;
    repeat (4) @(posedge I_CLK);
    pair(9'h155, 1'b1, 1'b1, 1'b1);
    wait_check();
    pair(shf(exp_acc) ^ RESIDUE ^ 9'h001, 1'b1, 1'b1, 1'b1);
    chk({7'h00, rvalid, rmatch}, 9'h002);
    complete_run();
  end
endmodule
